// >>> include/smsa_pkg.sv
// Shared constants and carrier types for the shared-memory SRAM access path.
package smsa_pkg;

   // ==========================================================================
   // Widths of the private bus and of the ISA side.
   localparam int PRIV_ADDR_W = 16;
   localparam int PRIV_DATA_W = 8;
   localparam int ADDR_LO_W = 10;
   localparam int ADDR_HI_W = 6;
   localparam int WORD_ADDR_W = PRIV_ADDR_W - 1;

   // ==========================================================================
   // Timing: system clock and private-bus clock periods, and derived counts.
   localparam int CLK_PERIOD_NS = 100;
   localparam int SRAM_PERIOD_NS = 50;
   localparam int SRAM_RD_PERIODS = 2;
   localparam int SRAM_WR_PERIODS = 3;
   // A private-bus period is a least time, so it rounds up to whole cycles.
   localparam int SRAM_PERIOD_CYC = (SRAM_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SRAM_RD_CYC = SRAM_RD_PERIODS * SRAM_PERIOD_CYC;
   localparam int SRAM_WR_CYC = SRAM_WR_PERIODS * SRAM_PERIOD_CYC;

   // ==========================================================================
   // Reset values and holding-register lane codes.
   localparam logic [WORD_ADDR_W-1:0] PF_ADDR_RST = 15'h0000;
   localparam logic [15:0] HOLD_DATA_RST = 16'h0000;
   localparam logic [1:0] LANE_NONE = 2'h0;
   localparam logic [1:0] LANE_LO = 2'h1;
   localparam logic [1:0] LANE_HI = 2'h2;
   localparam logic [1:0] LANE_BOTH = 2'h3;

   // ISA pins seen by the block, all active low where the suffix says so.
   typedef struct packed {
      logic [15:0] sa;
      logic [15:0] sd;
      logic memr_n;
      logic memw_n;
      logic ref_n;
      logic shared_mem_select_n;
      logic sbhe_n;
   } smsa_isa_type;

   // Private-bus SRAM pins driven by the block.
   typedef struct packed {
      logic [PRIV_ADDR_W-1:0] addr;
      logic [PRIV_DATA_W-1:0] wdata;
      logic data_oe;
      logic sram_output_enable_n;
      logic sram_write_strobe_n;
   } smsa_sram_type;

   // Main sequencer states.
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_WRITE = 3'b010,
      ST_FETCH = 3'b100
   } smsa_state_type;

endpackage

// >>> logic/smsa_sync.sv
// Two-flop synchroniser for a group of asynchronous pin inputs.
`timescale 1ns/1ns
module smsa_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk_i, // System clock.
   input wire logic rst_n_i, // Asynchronous reset, active low.
   input wire logic [W-1:0] d_i, // Asynchronous input.
   output logic [W-1:0] q_o // Synchronised output.
);

   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // ==========================================================================
   // Check.
   initial begin
      if (W < 1) begin
         $error("smsa_sync: width must be at least one");
      end
   end

   // The first stage is read by the second stage only, to keep metastability contained.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end else begin
         meta_q <= d_i;
         sync_q <= meta_q;
      end
   end

   assign q_o = sync_q;

endmodule

// >>> logic/smsa_sram_seq.sv
// Private-bus SRAM read and write strobe sequencer.
`timescale 1ns/1ns
module smsa_sram_seq
   import smsa_pkg::*;
#(
   parameter int RD_CYC = SRAM_RD_CYC,
   parameter int WR_CYC = SRAM_WR_CYC
) (
   input wire logic clk_i, // System clock.
   input wire logic rst_n_i, // Asynchronous reset, active low.
   input wire logic start_i, // Start one byte access.
   input wire logic write_i, // High for a write, low for a read.
   input wire logic [PRIV_ADDR_W-1:0] addr_i, // Byte address.
   input wire logic [PRIV_DATA_W-1:0] wdata_i, // Write byte.
   input wire logic [PRIV_DATA_W-1:0] rdata_i, // Private data bus input.
   output logic ready_o, // A start is accepted this cycle.
   output logic done_o, // Last cycle of the access.
   output logic [PRIV_DATA_W-1:0] rdata_o, // Byte read by the last read access.
   output smsa_pkg::smsa_sram_type sram_o // SRAM pins.
);

   logic active_q;
   logic wr_q;
   logic [1:0] cnt_q;
   logic [PRIV_ADDR_W-1:0] addr_q;
   logic [PRIV_DATA_W-1:0] wdata_q;
   logic we_n_q;
   logic take;

   // ==========================================================================
   // Checks.
   initial begin
      if (RD_CYC < 1 || RD_CYC > 3 || WR_CYC != 3) begin
         $error("smsa_sram_seq: access lengths not supported");
      end
   end

   assign done_o = active_q && (cnt_q == (wr_q ? 2'(WR_CYC - 1) : 2'(RD_CYC - 1)));
   assign ready_o = !active_q || done_o;
   assign take = start_i && ready_o;

   // Access timing; a new access may follow in the very next cycle.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         active_q <= 1'b0;
         wr_q <= 1'b0;
         cnt_q <= 2'h0;
         addr_q <= '0;
         wdata_q <= '0;
      end else if (take) begin
         active_q <= 1'b1;
         wr_q <= write_i;
         cnt_q <= 2'h0;
         addr_q <= addr_i;
         wdata_q <= wdata_i;
      end else if (done_o) begin
         active_q <= 1'b0;
      end else if (active_q) begin
         cnt_q <= cnt_q + 2'h1;
      end
   end

   // The data is sampled at the edge that ends the second period.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= '0;
      end else if (done_o && !wr_q) begin
         rdata_o <= rdata_i;
      end
   end

   // The strobe runs on the falling edge so that address and data settle half a
   // period before it and stay half a period after it.
   always_ff @(negedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         we_n_q <= 1'b1;
      end else begin
         we_n_q <= !(active_q && wr_q && cnt_q != 2'h2);
      end
   end

   // Chip select is not driven here; the SRAM select is tied active on the board.
   always_comb begin
      sram_o.addr = addr_q;
      sram_o.wdata = wdata_q;
      sram_o.data_oe = active_q && wr_q;
      sram_o.sram_output_enable_n = !(active_q && !wr_q);
      sram_o.sram_write_strobe_n = we_n_q;
   end

   // ==========================================================================
   // Assertions.
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   property p_rd_len;
      start_i && ready_o && !write_i |=> !sram_o.sram_output_enable_n [*2] ##1 done_o == 1'b0;
   endproperty
   a_rd_len: assert property (p_rd_len) else $error("read not two cycles");

   property p_wr_strobe;
      start_i && ready_o && write_i |=> !sram_o.sram_write_strobe_n [*2] ##1
         sram_o.sram_write_strobe_n;
   endproperty
   a_wr_strobe: assert property (p_wr_strobe) else $error("write strobe misplaced");

   property p_wr_addr;
      start_i && ready_o && write_i |=> sram_o.data_oe ##1
         (sram_o.data_oe && $stable(sram_o.addr)) [*2];
   endproperty
   a_wr_addr: assert property (p_wr_addr) else $error("write address not held");

   c_write: cover property (start_i && ready_o && write_i);

endmodule

// >>> logic/smsa_top.sv
// Shared-memory SRAM access path between the ISA bus and the private bus.
`timescale 1ns/1ns
module smsa_top
   import smsa_pkg::*;
(
   input wire logic clk_i, // System clock.
   input wire logic rst_n_i, // Asynchronous reset, active low.
   input wire smsa_pkg::smsa_isa_type isa_i, // ISA pins, asynchronous.
   input wire logic priv_busy_i, // Another private bus master owns the bus.
   input wire logic priv_other_act_i, // Pulse: other private bus activity.
   input wire logic [smsa_pkg::PRIV_DATA_W-1:0] private_data_bus_i, // SRAM read data.
   output logic [15:0] sd_o, // System data output.
   output logic sd_lo_oe_o, // Drive system data bits 7:0.
   output logic sd_hi_oe_o, // Drive system data bits 15:8.
   output logic iochrdy_o, // Ready pin level when enabled, always low.
   output logic iochrdy_oe_o, // Pull ready low (wait state).
   output logic upper_addr_buffer_enable_o, // Buffer ISA address 15:10 onto private bus.
   output logic priv_hi_addr_oe_o, // Block drives private address 15:10 itself.
   output smsa_pkg::smsa_sram_type sram_o // SRAM pins.
);

   import smsa_pkg::*;

   // ==========================================================================
   // Input synchronisation.
   localparam int ISA_W = $bits(smsa_isa_type);
   localparam logic [ISA_W-1:0] ISA_IDLE = {16'h0000, 16'h0000, 5'h1F};

   smsa_isa_type isa_s;
   logic [ISA_W-1:0] isa_s_raw;

   smsa_sync #(
      .W(ISA_W),
      .RST_VAL(ISA_IDLE)
   ) u_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .d_i(isa_i),
      .q_o(isa_s_raw)
   );

   assign isa_s = smsa_isa_type'(isa_s_raw);

   // ==========================================================================
   // Decode of memory cycles.
   logic sel;
   logic rd_req;
   logic wr_req;
   logic [WORD_ADDR_W-1:0] isa_word;

   // The select is only honoured with refresh inactive; the I/O enable plays no part.
   assign sel = !isa_s.shared_mem_select_n && isa_s.ref_n;
   assign rd_req = sel && !isa_s.memr_n;
   assign wr_req = sel && !isa_s.memw_n;
   assign isa_word = isa_s.sa[15:1];

   // ==========================================================================
   // State declarations.
   smsa_state_type st_q;
   logic sbhe_seen_q;
   logic wr_taken_q;
   logic hold_full_q;
   logic [WORD_ADDR_W-1:0] hold_addr_q;
   logic [15:0] hold_data_q;
   logic [1:0] hold_lane_q;
   logic pf_valid_q;
   logic pf_want_q;
   logic [WORD_ADDR_W-1:0] pf_addr_q;
   logic [WORD_ADDR_W-1:0] pf_next_q;
   logic [15:0] pf_data_q;
   logic [WORD_ADDR_W-1:0] fetch_addr_q;
   logic fetch_idx_q;
   logic serving_q;
   logic upper_addr_buffer_enable_q;

   logic seq_start;
   logic seq_write;
   logic [PRIV_ADDR_W-1:0] seq_addr;
   logic [PRIV_DATA_W-1:0] seq_wdata;
   logic seq_ready;
   logic seq_done;
   logic wide;
   logic hit;
   logic miss_fetch;
   logic bg_fetch;
   logic wr_take;
   logic flush_last;
   logic serve_go;
   logic serve_end;
   logic [1:0] wr_lanes;
   logic wr_hi_first;

   // ==========================================================================
   // Bus width: 16-bit cycles from the first cycle that shows the byte-high enable.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sbhe_seen_q <= 1'b0;
      end else if (!isa_s.sbhe_n) begin
         sbhe_seen_q <= 1'b1;
      end
   end

   assign wide = sbhe_seen_q || !isa_s.sbhe_n;

   // ==========================================================================
   // Holding register. A write is taken once per ISA cycle, and only when empty,
   // so the fill and the drain can never collide in one cycle.
   assign wr_take = wr_req && !wr_taken_q && !hold_full_q;
   assign flush_last = (st_q == ST_WRITE) && seq_done && (wr_lanes != LANE_BOTH);
   assign wr_lanes = hold_lane_q;

   always_comb begin
      wr_hi_first = 1'b0;
      if (hold_lane_q == LANE_HI) begin
         wr_hi_first = 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_taken_q <= 1'b0;
      end else if (!wr_req) begin
         wr_taken_q <= 1'b0;
      end else if (wr_take) begin
         wr_taken_q <= 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hold_full_q <= 1'b0;
         hold_addr_q <= PF_ADDR_RST;
         hold_data_q <= HOLD_DATA_RST;
         hold_lane_q <= LANE_NONE;
      end else if (wr_take) begin
         hold_full_q <= 1'b1;
         hold_addr_q <= isa_word;
         if (wide && !isa_s.sbhe_n) begin
            hold_data_q <= isa_s.sd;
            hold_lane_q <= isa_s.sa[0] ? LANE_HI : LANE_BOTH;
         end else begin
            // Narrow cycles carry either byte on the low lane.
            hold_data_q <= {isa_s.sd[7:0], isa_s.sd[7:0]};
            hold_lane_q <= isa_s.sa[0] ? LANE_HI : LANE_LO;
         end
      end else if ((st_q == ST_WRITE) && seq_done) begin
         if (hold_lane_q == LANE_BOTH) begin
            hold_lane_q <= LANE_HI;
         end else begin
            hold_lane_q <= LANE_NONE;
            hold_full_q <= 1'b0;
         end
      end
   end

   // ==========================================================================
   // Private bus sequencing. Write-back of the holding register goes first.
   assign hit = pf_valid_q && (pf_addr_q == isa_word);
   assign miss_fetch = rd_req && !serving_q && !hit;
   assign bg_fetch = !rd_req && !wr_req && pf_want_q && !pf_valid_q;

   always_comb begin
      seq_start = 1'b0;
      seq_write = 1'b0;
      seq_addr = {fetch_addr_q, fetch_idx_q};
      seq_wdata = hold_data_q[7:0];
      unique case (st_q)
         ST_IDLE: begin
            if (hold_full_q && !priv_busy_i) begin
               seq_start = 1'b1;
               seq_write = 1'b1;
               seq_addr = {hold_addr_q, wr_hi_first};
               seq_wdata = wr_hi_first ? hold_data_q[15:8] : hold_data_q[7:0];
            end else if ((miss_fetch || bg_fetch) && !priv_busy_i) begin
               seq_start = 1'b1;
               seq_addr = {miss_fetch ? isa_word : pf_next_q, 1'b0};
            end
         end
         ST_WRITE: begin
            if (seq_done && hold_lane_q == LANE_BOTH) begin
               seq_start = 1'b1;
               seq_write = 1'b1;
               seq_addr = {hold_addr_q, 1'b1};
               seq_wdata = hold_data_q[15:8];
            end
         end
         ST_FETCH: begin
            if (seq_done && !fetch_idx_q) begin
               seq_start = 1'b1;
               seq_addr = {fetch_addr_q, 1'b1};
            end
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q <= ST_IDLE;
         fetch_addr_q <= PF_ADDR_RST;
         fetch_idx_q <= 1'b0;
      end else begin
         unique case (st_q)
            ST_IDLE: begin
               if (seq_start && seq_write && seq_ready) begin
                  st_q <= ST_WRITE;
               end else if (seq_start && seq_ready) begin
                  st_q <= ST_FETCH;
                  fetch_addr_q <= seq_addr[PRIV_ADDR_W-1:1];
                  fetch_idx_q <= 1'b0;
               end
            end
            ST_WRITE: begin
               if (flush_last) begin
                  st_q <= ST_IDLE;
               end
            end
            ST_FETCH: begin
               if (seq_done) begin
                  fetch_idx_q <= 1'b1;
                  if (fetch_idx_q) begin
                     st_q <= ST_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // ==========================================================================
   // Prefetch buffer. Invalidation beats a fetch completing in the same cycle,
   // since stale data must never be served.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pf_valid_q <= 1'b0;
         pf_want_q <= 1'b0;
         pf_addr_q <= PF_ADDR_RST;
         pf_next_q <= PF_ADDR_RST;
         pf_data_q <= HOLD_DATA_RST;
      end else begin
         // The bus is taken at the sequencer's sampling edge; its own copy lands only then.
         if (st_q == ST_FETCH && seq_done) begin
            if (fetch_idx_q) begin
               pf_data_q[15:8] <= private_data_bus_i;
               pf_addr_q <= fetch_addr_q;
               pf_valid_q <= 1'b1;
               pf_want_q <= 1'b0;
            end else begin
               pf_data_q[7:0] <= private_data_bus_i;
            end
         end
         if (serve_end) begin
            pf_next_q <= pf_addr_q + 15'h0001;
            pf_want_q <= 1'b1;
            pf_valid_q <= 1'b0;
         end
         if (priv_other_act_i || st_q == ST_WRITE) begin
            pf_valid_q <= 1'b0;
         end
      end
   end

   // ==========================================================================
   // Read service: data stands on the bus until the read strobe goes away.
   assign serve_go = rd_req && !serving_q && hit && !priv_busy_i && st_q == ST_IDLE;
   assign serve_end = serving_q && !rd_req;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         serving_q <= 1'b0;
         sd_o <= 16'h0000;
         sd_lo_oe_o <= 1'b0;
         sd_hi_oe_o <= 1'b0;
      end else if (serve_go) begin
         serving_q <= 1'b1;
         if (wide && !isa_s.sbhe_n) begin
            sd_o <= pf_data_q;
            sd_lo_oe_o <= !isa_s.sa[0];
            sd_hi_oe_o <= 1'b1;
         end else begin
            // Narrow cycle: the addressed byte is swapped down to the low lane.
            sd_o <= {8'h00, isa_s.sa[0] ? pf_data_q[15:8] : pf_data_q[7:0]};
            sd_lo_oe_o <= 1'b1;
            sd_hi_oe_o <= 1'b0;
         end
      end else if (serve_end) begin
         serving_q <= 1'b0;
         sd_lo_oe_o <= 1'b0;
         sd_hi_oe_o <= 1'b0;
      end
   end

   // Upper address buffer: on while a granted read is in progress, but off from the first
   // cycle of a write-back, so that the buffer never fights the block's own address.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         upper_addr_buffer_enable_q <= 1'b0;
      end else begin
         upper_addr_buffer_enable_q <= rd_req && !priv_busy_i && !seq_write && st_q != ST_WRITE;
      end
   end

   // Ready is open drain: only ever pulled low; the level output stays low.
   assign iochrdy_o = 1'b0;
   assign iochrdy_oe_o = (rd_req && !serving_q) || (wr_req && !wr_taken_q && hold_full_q);
   assign upper_addr_buffer_enable_o = upper_addr_buffer_enable_q;
   assign priv_hi_addr_oe_o = !upper_addr_buffer_enable_q && st_q != ST_IDLE;

   smsa_sram_seq u_seq (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .start_i(seq_start),
      .write_i(seq_write),
      .addr_i(seq_addr),
      .wdata_i(seq_wdata),
      .rdata_i(private_data_bus_i),
      .ready_o(seq_ready),
      .done_o(seq_done),
      .rdata_o(),
      .sram_o(sram_o)
   );

   // ==========================================================================
   // Assertions.
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   property p_wr_stall;
      wr_req && !wr_taken_q && hold_full_q |-> iochrdy_oe_o;
   endproperty
   a_wr_stall: assert property (p_wr_stall) else $error("full holding register not stalling");

   property p_rd_stall;
      rd_req && priv_busy_i && !serving_q |-> iochrdy_oe_o ##1 !serving_q;
   endproperty
   a_rd_stall: assert property (p_rd_stall) else $error("read not stalled on busy bus");

   property p_release;
      $rose(serving_q) |-> !iochrdy_oe_o && (sd_lo_oe_o || sd_hi_oe_o);
   endproperty
   a_release: assert property (p_release) else $error("hit did not release ready");

   property p_drop;
      serving_q && !rd_req |=> !sd_lo_oe_o && !sd_hi_oe_o && !serving_q;
   endproperty
   a_drop: assert property (p_drop) else $error("data held after read strobe");

   property p_narrow;
      !sbhe_seen_q |-> !sd_hi_oe_o;
   endproperty
   a_narrow: assert property (p_narrow) else $error("high byte driven in 8-bit mode");

   property p_inval;
      priv_other_act_i |=> !pf_valid_q;
   endproperty
   a_inval: assert property (p_inval) else $error("prefetch survived other activity");

   property p_write_first;
      st_q == ST_IDLE && seq_start && !seq_write |-> !hold_full_q;
   endproperty
   a_write_first: assert property (p_write_first) else $error("fetch before write-back");

   property p_upper_addr_buffer_enable;
      upper_addr_buffer_enable_o |-> $past(rd_req) && !$past(priv_busy_i);
   endproperty
   a_upper_addr_buffer_enable: assert property (p_upper_addr_buffer_enable) else $error("buffer enable without granted read");

   property p_fetch_two;
      st_q == ST_IDLE ##1 st_q == ST_FETCH |-> (st_q == ST_FETCH) [*4] ##1 st_q == ST_IDLE;
   endproperty
   a_fetch_two: assert property (p_fetch_two) else $error("fetch shorter than two bytes");

   c_hit: cover property (rd_req && hit && serve_go);
   c_miss: cover property (miss_fetch && seq_start);
   c_wr_wait: cover property (wr_req && hold_full_q && !wr_taken_q);

endmodule

// >>> verification/smsa_sram_model.sv
// Behavioural 8-bit SRAM on the private bus, chip select tied active.
`timescale 1ns/1ns
module smsa_sram_model
   import smsa_pkg::*;
(
   input wire smsa_pkg::smsa_sram_type sram_i, // SRAM pins from the block.
   input wire logic [PRIV_ADDR_W-1:0] addr_i, // Resolved private address.
   output logic [PRIV_DATA_W-1:0] rdata_o // Private data bus back to the block.
);
   logic [7:0] mem_q [0:65535];
   logic [7:0] last_q = 8'h00;
   // A write lands as the strobe rises, while address and data still hold.
   always @(posedge sram_i.sram_write_strobe_n) begin
      mem_q[addr_i] = sram_i.wdata;
   end
   // A released bus shows the inverse of the last byte, so stale data never matches.
   always @* begin
      if (!sram_i.sram_output_enable_n) begin
         rdata_o = mem_q[addr_i];
         last_q = rdata_o;
      end else begin
         rdata_o = ~last_q;
      end
   end
endmodule

// >>> verification/smsa_top_tb.sv
// Self-checking bench for the shared-memory SRAM access path.
`timescale 1ns/1ns
module smsa_top_tb;
   import smsa_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic busy = 1'b0;
   logic other = 1'b0;
   smsa_isa_type isa = {16'h0000, 16'h0000, 5'h1f};
   logic [7:0] prd;
   logic [15:0] sd;
   logic [15:0] got;
   logic [15:0] lanes;
   logic lo_oe, hi_oe, rdy_oe, ube, hae;
   smsa_sram_type sram;
   int err_total = 0;
   int n_compared = 0;
   int w;
   // The upper address bits come from the external buffer while it is enabled, from the
   // block while it drives them, and read inverted when nobody does.
   smsa_sram_model mem (.sram_i(sram), .rdata_o(prd),
      .addr_i({ube ? isa.sa[15:10] : hae ? sram.addr[15:10] : ~sram.addr[15:10],
      sram.addr[9:0]}));
   smsa_top dut (.clk_i(clk), .rst_n_i(rst_n), .isa_i(isa), .priv_busy_i(busy),
      .priv_other_act_i(other), .private_data_bus_i(prd), .sd_o(sd), .sd_lo_oe_o(lo_oe),
      .sd_hi_oe_o(hi_oe), .iochrdy_o(), .iochrdy_oe_o(rdy_oe),
      .upper_addr_buffer_enable_o(ube), .priv_hi_addr_oe_o(hae), .sram_o(sram));
   // ==========================================================================
   // Clock and shared tasks.
   always #50 clk = ~clk;
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // One ISA memory cycle; w counts edges until ready is seen released.
   task automatic cyc(input logic wr, input logic [15:0] a, input logic [15:0] d,
      input logic bhe_n);
      isa.sa = a;
      isa.sd = d;
      isa.sbhe_n = bhe_n;
      isa.shared_mem_select_n = 1'b0;
      isa.memw_n = !wr;
      isa.memr_n = wr;
      w = 0;
      do begin
         @(posedge clk);
         #10;
         w++;
         if (w > 80) begin
            err_total++;
            give_verdict();
         end
      end while (w < 3 || rdy_oe !== 1'b0);
      @(posedge clk);
      #10;
      got = sd;
      lanes = {14'h0000, hi_oe, lo_oe};
      isa = {a, ~d, 5'h1f};
      @(posedge clk);
      #10;
   endtask
   // ==========================================================================
   // Scenarios.
   task automatic s_eight();
      cyc(1'b1, 16'h4a00, 16'h005a, 1'b1);
      cyc(1'b0, 16'h4a00, 16'h0000, 1'b1);
      chk(lanes, 16'h0001);
      chk({8'h00, got[7:0]}, 16'h005a);
   endtask
   task automatic s_word();
      cyc(1'b1, 16'h4c00, 16'h1234, 1'b0);
      cyc(1'b1, 16'h4c02, 16'h5678, 1'b0);
      chk({15'h0000, w >= 5}, 16'h0001);
      cyc(1'b1, 16'h4c04, 16'h9abc, 1'b0);
      repeat (20) @(posedge clk);
      #10;
   endtask
   task automatic s_prefetch();
      cyc(1'b0, 16'h4c00, 16'h0000, 1'b0);
      chk({15'h0000, w >= 7}, 16'h0001);
      chk(got, 16'h1234);
      chk(lanes, 16'h0003);
      repeat (10) @(posedge clk);
      #10;
      cyc(1'b0, 16'h4c02, 16'h0000, 1'b0);
      chk({15'h0000, w <= 4}, 16'h0001);
      chk(got, 16'h5678);
      repeat (10) @(posedge clk);
      #10;
      other = 1'b1;
      @(posedge clk);
      #10;
      other = 1'b0;
      cyc(1'b0, 16'h4c04, 16'h0000, 1'b0);
      chk({15'h0000, w >= 7}, 16'h0001);
      chk(got, 16'h9abc);
   endtask
   task automatic s_busy();
      busy = 1'b1;
      fork
         cyc(1'b0, 16'h4c00, 16'h0000, 1'b0);
         begin
            repeat (12) @(posedge clk);
            #10;
            busy = 1'b0;
         end
      join
      chk({15'h0000, w >= 12}, 16'h0001);
      chk(got, 16'h1234);
   endtask
   // A reset in mid-run empties the prefetch; a write during refresh must not land.
   task automatic s_reset();
      rst_n = 1'b0;
      @(posedge clk);
      #10;
      rst_n = 1'b1;
      repeat (2) @(posedge clk);
      #10;
      isa.ref_n = 1'b0;
      cyc(1'b1, 16'h4c00, 16'h00ee, 1'b1);
      cyc(1'b0, 16'h4c00, 16'h0000, 1'b1);
      chk({15'h0000, w >= 7}, 16'h0001);
      chk({8'h00, got[7:0]}, 16'h0034);
      chk(lanes, 16'h0001);
      cyc(1'b0, 16'h4c01, 16'h0000, 1'b1);
      chk({8'h00, got[7:0]}, 16'h0012);
   endtask
   // Reset is held for five cycles, then the scenarios run in order.
   initial begin
      repeat (5) @(posedge clk);
      #10;
      rst_n = 1'b1;
      repeat (2) @(posedge clk);
      #10;
      s_eight();
      s_word();
      s_prefetch();
      s_busy();
      s_reset();
      give_verdict();
   end
endmodule
